// *** tx_shaper_pkg.sv ***
package tx_shaper_pkg;
	localparam logic [7:0] ADDR_SYM0_HI = 8'h4D;
	localparam logic [7:0] ADDR_SYM0_LO = 8'h4E;
	localparam logic [7:0] ADDR_SYM1_HI = 8'h4F;
	localparam logic [7:0] ADDR_SYM1_LO = 8'h50;
	localparam logic [7:0] ADDR_SYM2 = 8'h51;
	localparam logic [7:0] ADDR_SYM3 = 8'h52;
	localparam logic [7:0] ADDR_LEN10 = 8'h53;
	localparam logic [7:0] ADDR_LEN32 = 8'h54;
	localparam logic [7:0] ADDR_BURST_CTRL = 8'h55;
	localparam logic [7:0] ADDR_MOD10 = 8'h56;
	localparam logic [7:0] ADDR_MOD32 = 8'h57;
	localparam logic [7:0] ADDR_BURST_LEN = 8'h60;
	localparam logic [7:0] ADDR_FREQ10 = 8'h61;
	localparam logic [7:0] ADDR_TX_CTRL = 8'h62;

	localparam logic [7:0] MASK_BURST_CTRL = 8'h77;
	localparam logic [7:0] MASK_MOD = 8'h7F;
	localparam logic [7:0] MASK_LEN32 = 8'h77;
	localparam logic [7:0] MASK_FREQ10 = 8'h08;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	localparam int BIT_S1_LEVEL = 6;
	localparam int BIT_S1_ALONE = 5;
	localparam int BIT_S1_ON = 4;
	localparam int BIT_S0_LEVEL = 2;
	localparam int BIT_S0_ALONE = 1;
	localparam int BIT_S0_ON = 0;
	localparam int BIT_SC_FREQ = 3;
	localparam int BIT_GO = 7;

	localparam int CLK_HZ = 125_000_000;
	localparam int SC_LOW_HZ = 424_000;
	localparam int SC_HIGH_HZ = 848_000;
	localparam int BIT_RATE_HZ = 106_000;
	localparam int SC_LOW_HALF = CLK_HZ / (2 * SC_LOW_HZ);
	localparam int SC_HIGH_HALF = CLK_HZ / (2 * SC_HIGH_HZ);
	localparam int QUARTER_CYCLES_DEF = CLK_HZ / (4 * BIT_RATE_HZ);

	typedef struct packed {
		logic reserved_bit;
		logic miller_on;
		logic [1:0] pulse_kind;
		logic invert;
		logic [2:0] envelope;
	} mod_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} bus_req_t;

	typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_PATTERN} seq_state_t;
endpackage

// *** tx_bit_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_bit_timer
	import tx_shaper_pkg::*;
#(
	parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEF,
	parameter int SC_LOW = SC_LOW_HALF,
	parameter int SC_HIGH = SC_HIGH_HALF
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic run,
	input wire logic sc_high_sel,
	output logic [1:0] quarter,
	output logic bit_end,
	output logic sc_level
);
	logic [15:0] q_cnt_q;
	logic [1:0] quarter_q;
	logic [7:0] sc_cnt_q;
	logic sc_q;
	logic q_last;
	logic [7:0] half_m1;

	assign q_last = (q_cnt_q == 16'(QUARTER_CYCLES - 1));
	assign bit_end = run && q_last && (quarter_q == 2'h3);
	assign quarter = quarter_q;
	assign sc_level = sc_q;
	// Subcarrier half period
	assign half_m1 = sc_high_sel ? 8'(SC_HIGH - 1) : 8'(SC_LOW - 1);

	// Bit quarter timing
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q_cnt_q <= 16'h0000;
			quarter_q <= 2'h0;
		end else if (clk_en) begin
			if (!run) begin
				q_cnt_q <= 16'h0000;
				quarter_q <= 2'h0;
			end else if (q_last) begin
				q_cnt_q <= 16'h0000;
				quarter_q <= quarter_q + 2'h1;
			end else begin
				q_cnt_q <= q_cnt_q + 16'h0001;
			end
		end
	end

	// Subcarrier square wave
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sc_cnt_q <= 8'h00;
			sc_q <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				sc_cnt_q <= 8'h00;
				sc_q <= 1'b0;
			end else if (sc_cnt_q >= half_m1) begin
				sc_cnt_q <= 8'h00;
				sc_q <= ~sc_q;
			end else begin
				sc_cnt_q <= sc_cnt_q + 8'h01;
			end
		end
	end

	a_sc_half_period: assert property (@(posedge mclk)
		disable iff (!reset_n)
		$past(clk_en) && $past(run) && $stable(sc_high_sel)
		&& $changed(sc_q)
		|-> $past(sc_cnt_q) == half_m1)
		else $error("subcarrier half period wrong");
endmodule
`default_nettype wire

// *** tx_envelope_shaper.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_envelope_shaper
	import tx_shaper_pkg::*;
#(
	parameter bit PAIR_B = 1'b0
) (
	input wire mod_cfg_t cfg,
	input wire logic data_bit,
	input wire logic prev_bit,
	input wire logic [1:0] quarter,
	input wire logic sc_level,
	output logic level
);
	function automatic logic pulse_window(input logic [1:0] kind,
		input logic [1:0] q);
		logic w;
		w = 1'b0;
		unique case (kind)
			2'h0: w = 1'b0;
			2'h1: w = (q == 2'h0);
			2'h2: w = q[1];
			2'h3: w = (q == 2'h2);
		endcase
		return w;
	endfunction

	logic second_half;
	logic env_level;
	logic shaped;

	assign second_half = quarter[1];

	// Envelope coding
	always_comb begin
		env_level = 1'b0;
		unique case (cfg.envelope)
			3'h0: env_level = data_bit;
			3'h1: env_level = data_bit ^ second_half;
			3'h2: env_level = (data_bit ^ second_half) & sc_level;
			3'h3: env_level = data_bit ^ sc_level;
			3'h4: env_level = data_bit & second_half;
			3'h5: env_level = PAIR_B ? (data_bit & ~second_half)
				: (data_bit & second_half);
			default: env_level = 1'b0;
		endcase
	end

	// Pulse modulation and modified Miller
	always_comb begin
		shaped = env_level;
		if (cfg.miller_on && cfg.pulse_kind == 2'h1) begin
			shaped = data_bit ? pulse_window(2'h3, quarter)
				: (!prev_bit && pulse_window(2'h1, quarter));
		end else if (cfg.pulse_kind != 2'h0) begin
			shaped = env_level & pulse_window(cfg.pulse_kind, quarter);
		end
	end

	assign level = shaped ^ cfg.invert;
endmodule
`default_nettype wire

// *** tx_symbol_shaper.sv ***
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tx_symbol_shaper
	import tx_shaper_pkg::*;
#(
	parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	output logic tx_out,
	output logic tx_active
);
	function automatic logic [3:0] sym_len(input logic [1:0] s,
		input logic [7:0] l10, input logic [7:0] l32);
		logic [3:0] n;
		n = 4'h0;
		unique case (s)
			2'h0: n = l10[3:0];
			2'h1: n = l10[7:4];
			2'h2: n = {1'b0, l32[2:0]};
			2'h3: n = {1'b0, l32[6:4]};
		endcase
		return n;
	endfunction

	logic [15:0] sym0_pattern_q;
	logic [15:0] sym1_pattern_q;
	logic [7:0] sym2_pattern_q;
	logic [7:0] sym3_pattern_q;
	logic [7:0] len10_q;
	logic [7:0] len32_q;
	logic [7:0] burst_ctrl_q;
	mod_cfg_t mod10_q;
	mod_cfg_t mod32_q;
	logic [7:0] burst_len_q;
	logic [7:0] freq10_q;
	logic [7:0] rdata_q;

	seq_state_t state_q;
	logic [1:0] cur_sym_q;
	logic [7:0] burst_cnt_q;
	logic [3:0] bit_idx_q;
	logic prev_bit_q;
	logic tx_out_q;
	logic [4:0] bits_sent_q;

	logic go;
	logic [1:0] go_sym;
	logic go_burst_on;
	logic go_alone;
	logic cur_alone;
	logic cur_level;
	logic raw_bit;
	logic pat_bit;
	logic [1:0] quarter;
	logic bit_end;
	logic sc_level;
	logic level_a;
	logic level_b;
	logic pair_b_sel;

	wire logic [7:0] wd = bus_req.wdata;
	wire logic [7:0] ad = bus_req.addr;

	assign go = bus_req.we && ad == ADDR_TX_CTRL && wd[BIT_GO]
		&& state_q == ST_IDLE;
	assign go_sym = wd[1:0];
	assign go_burst_on = (go_sym == 2'h0) ? burst_ctrl_q[BIT_S0_ON]
		: (go_sym == 2'h1) ? burst_ctrl_q[BIT_S1_ON] : 1'b0;
	assign go_alone = (go_sym == 2'h0) ? burst_ctrl_q[BIT_S0_ALONE]
		: (go_sym == 2'h1) ? burst_ctrl_q[BIT_S1_ALONE] : 1'b0;
	assign cur_alone = cur_sym_q[0] ? burst_ctrl_q[BIT_S1_ALONE]
		: burst_ctrl_q[BIT_S0_ALONE];
	assign cur_level = cur_sym_q[0] ? burst_ctrl_q[BIT_S1_LEVEL]
		: burst_ctrl_q[BIT_S0_LEVEL];

	always_comb begin
		pat_bit = 1'b0;
		unique case (cur_sym_q)
			2'h0: pat_bit = sym0_pattern_q[bit_idx_q];
			2'h1: pat_bit = sym1_pattern_q[bit_idx_q];
			2'h2: pat_bit = sym2_pattern_q[bit_idx_q[2:0]];
			2'h3: pat_bit = sym3_pattern_q[bit_idx_q[2:0]];
		endcase
	end

	assign raw_bit = (state_q == ST_BURST) ? cur_level : pat_bit;
	assign pair_b_sel = cur_sym_q[1];

	// Register writes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sym0_pattern_q <= {RESET_BYTE, RESET_BYTE};
			sym1_pattern_q <= {RESET_BYTE, RESET_BYTE};
			sym2_pattern_q <= RESET_BYTE;
			sym3_pattern_q <= RESET_BYTE;
			len10_q <= RESET_BYTE;
			len32_q <= RESET_BYTE;
			burst_ctrl_q <= RESET_BYTE;
			mod10_q <= mod_cfg_t'(RESET_BYTE);
			mod32_q <= mod_cfg_t'(RESET_BYTE);
			burst_len_q <= RESET_BYTE;
			freq10_q <= RESET_BYTE;
		end else if (clk_en && bus_req.we) begin
			unique case (ad)
				ADDR_SYM0_HI: sym0_pattern_q[15:8] <= wd;
				ADDR_SYM0_LO: sym0_pattern_q[7:0] <= wd;
				ADDR_SYM1_HI: sym1_pattern_q[15:8] <= wd;
				ADDR_SYM1_LO: sym1_pattern_q[7:0] <= wd;
				ADDR_SYM2: sym2_pattern_q <= wd;
				ADDR_SYM3: sym3_pattern_q <= wd;
				ADDR_LEN10: len10_q <= wd;
				ADDR_LEN32: len32_q <= wd & MASK_LEN32;
				ADDR_BURST_CTRL: burst_ctrl_q <= wd & MASK_BURST_CTRL;
				ADDR_MOD10: mod10_q <= mod_cfg_t'(wd & MASK_MOD);
				ADDR_MOD32: mod32_q <= mod_cfg_t'(wd & MASK_MOD);
				ADDR_BURST_LEN: burst_len_q <= wd;
				ADDR_FREQ10: freq10_q <= wd & MASK_FREQ10;
				default: ;
			endcase
		end
	end

	// Register reads, one cycle later
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= RESET_BYTE;
		end else if (clk_en) begin
			if (bus_req.re) begin
				unique case (ad)
					ADDR_SYM0_HI: rdata_q <= sym0_pattern_q[15:8];
					ADDR_SYM0_LO: rdata_q <= sym0_pattern_q[7:0];
					ADDR_SYM1_HI: rdata_q <= sym1_pattern_q[15:8];
					ADDR_SYM1_LO: rdata_q <= sym1_pattern_q[7:0];
					ADDR_SYM2: rdata_q <= sym2_pattern_q;
					ADDR_SYM3: rdata_q <= sym3_pattern_q;
					ADDR_LEN10: rdata_q <= len10_q;
					ADDR_LEN32: rdata_q <= len32_q;
					ADDR_BURST_CTRL: rdata_q <= burst_ctrl_q;
					ADDR_MOD10: rdata_q <= mod10_q;
					ADDR_MOD32: rdata_q <= mod32_q;
					ADDR_BURST_LEN: rdata_q <= burst_len_q;
					ADDR_FREQ10: rdata_q <= freq10_q;
					ADDR_TX_CTRL: rdata_q <= {2'b00, cur_sym_q, 3'b000,
						state_q != ST_IDLE};
					default: rdata_q <= RESET_BYTE;
				endcase
			end else begin
				rdata_q <= RESET_BYTE;
			end
		end
	end

	// Symbol sequencer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cur_sym_q <= 2'h0;
			burst_cnt_q <= 8'h00;
			bit_idx_q <= 4'h0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_IDLE: begin
					if (go) begin
						cur_sym_q <= go_sym;
						burst_cnt_q <= burst_len_q;
						bit_idx_q <= sym_len(go_sym, len10_q, len32_q);
						if (go_burst_on) begin
							state_q <= ST_BURST;
						end else if (!go_alone) begin
							state_q <= ST_PATTERN;
						end
					end
				end
				ST_BURST: begin
					if (bit_end) begin
						if (burst_cnt_q != 8'h00) begin
							burst_cnt_q <= burst_cnt_q - 8'h01;
						end else if (cur_alone) begin
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_PATTERN;
						end
					end
				end
				ST_PATTERN: begin
					if (bit_end) begin
						if (bit_idx_q == 4'h0) begin
							state_q <= ST_IDLE;
						end else begin
							bit_idx_q <= bit_idx_q - 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Previous bit for Miller and output register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_bit_q <= 1'b0;
			tx_out_q <= 1'b0;
		end else if (clk_en) begin
			if (go) begin
				prev_bit_q <= 1'b0;
			end else if (bit_end) begin
				prev_bit_q <= raw_bit;
			end
			if (state_q == ST_IDLE) begin
				tx_out_q <= 1'b0;
			end else begin
				tx_out_q <= pair_b_sel ? level_b : level_a;
			end
		end
	end

	// Pattern bit counter for checking
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bits_sent_q <= 5'h00;
		end else if (clk_en) begin
			if (go) begin
				bits_sent_q <= 5'h00;
			end else if (state_q == ST_PATTERN && bit_end) begin
				bits_sent_q <= bits_sent_q + 5'h01;
			end
		end
	end

	tx_bit_timer #(
		.QUARTER_CYCLES(QUARTER_CYCLES)
	) u_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.run(state_q != ST_IDLE),
		.sc_high_sel(freq10_q[BIT_SC_FREQ]),
		.quarter(quarter),
		.bit_end(bit_end),
		.sc_level(sc_level)
	);

	tx_envelope_shaper #(
		.PAIR_B(1'b0)
	) u_pair_a (
		.cfg(mod10_q),
		.data_bit(raw_bit),
		.prev_bit(prev_bit_q),
		.quarter(quarter),
		.sc_level(sc_level),
		.level(level_a)
	);

	tx_envelope_shaper #(
		.PAIR_B(1'b1)
	) u_pair_b (
		.cfg(mod32_q),
		.data_bit(raw_bit),
		.prev_bit(prev_bit_q),
		.quarter(quarter),
		.sc_level(sc_level),
		.level(level_b)
	);

	assign bus_rdata = rdata_q;
	assign tx_out = tx_out_q;
	assign tx_active = (state_q != ST_IDLE);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	a_burst1_level: assert property (
		clk_en && state_q == ST_BURST && cur_sym_q == 2'h1
		&& mod10_q[6:0] == 7'h00
		|=> tx_out_q == $past(burst_ctrl_q[BIT_S1_LEVEL]))
		else $error("symbol 1 burst level wrong");
	a_burst0_level: assert property (
		clk_en && state_q == ST_BURST && cur_sym_q == 2'h0
		&& mod10_q[6:0] == 7'h00
		|=> tx_out_q == $past(burst_ctrl_q[BIT_S0_LEVEL]))
		else $error("symbol 0 burst level wrong");
	a_burst1_alone: assert property (
		clk_en && state_q == ST_BURST && cur_sym_q == 2'h1 && bit_end
		&& burst_cnt_q == 8'h00 && burst_ctrl_q[BIT_S1_ALONE]
		|=> state_q == ST_IDLE)
		else $error("symbol 1 burst alone sent pattern");
	a_burst0_alone: assert property (
		clk_en && state_q == ST_BURST && cur_sym_q == 2'h0 && bit_end
		&& burst_cnt_q == 8'h00 && burst_ctrl_q[BIT_S0_ALONE]
		|=> state_q == ST_IDLE)
		else $error("symbol 0 burst alone sent pattern");
	a_burst1_start: assert property (
		clk_en && go && go_sym == 2'h1
		|=> (state_q == ST_BURST) == $past(burst_ctrl_q[BIT_S1_ON]))
		else $error("symbol 1 burst enable ignored");
	a_burst0_start: assert property (
		clk_en && go && go_sym == 2'h0
		|=> (state_q == ST_BURST) == $past(burst_ctrl_q[BIT_S0_ON]))
		else $error("symbol 0 burst enable ignored");
	a_pattern_bit_count: assert property (
		clk_en && state_q == ST_PATTERN && bit_end && bit_idx_q == 4'h0
		|-> 5'(bits_sent_q) + 5'h01
		== {1'b0, sym_len(cur_sym_q, len10_q, len32_q)} + 5'h01)
		else $error("pattern bit count wrong");
	a_reserved_read_zero: assert property (
		clk_en && bus_req.re && (ad == ADDR_BURST_CTRL
		|| ad == ADDR_MOD10 || ad == ADDR_MOD32)
		|=> bus_rdata[7] == 1'b0
		&& ($past(ad) != ADDR_BURST_CTRL || bus_rdata[3] == 1'b0))
		else $error("reserved bit read nonzero");
	a_reserved_env_off: assert property (
		clk_en && state_q != ST_IDLE && !pair_b_sel
		&& mod10_q.envelope[2:1] == 2'h3 && mod10_q.pulse_kind == 2'h0
		|=> tx_out_q == $past(mod10_q.invert))
		else $error("reserved envelope drove output");
	a_miller_quiet: assert property (
		clk_en && state_q != ST_IDLE && !pair_b_sel && mod10_q.miller_on
		&& mod10_q.pulse_kind == 2'h1 && quarter == 2'h1
		|=> tx_out_q == $past(mod10_q.invert))
		else $error("Miller pulse in second quarter");
endmodule
`default_nettype wire

// *** rf_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rf_card_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic tx_out,
	input wire logic tx_active,
	output logic [63:0] qbits,
	output int nq
);
	logic act_q;
	logic [1:0] cnt_q;
	// Field level lags the active flag by one cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			act_q <= 1'b0;
			cnt_q <= 2'b00;
			qbits <= '0;
			nq <= 0;
		end else begin
			act_q <= tx_active;
			cnt_q <= act_q ? cnt_q + 2'b01 : 2'b00;
			if (tx_active && !act_q) begin
				qbits <= '0;
				nq <= 0;
			end else if (act_q && cnt_q == 2'b10) begin
				qbits <= {qbits[62:0], tx_out};
				nq <= nq + 1;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb_tx_symbol_shaper.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_tx_symbol_shaper;
	import tx_shaper_pkg::*;
	logic mclk;
	logic reset_n;
	logic clk_en;
	bus_req_t bus_req;
	logic [7:0] bus_rdata;
	logic tx_out;
	logic tx_active;
	logic [63:0] qbits;
	int nq;
	int errors;
	int comparisons;
	bit pb_s;
	bit inv_s;
	bit mil_s;
	int env_s;
	int kind_s;
	logic [7:0] ra [3] = '{ADDR_BURST_CTRL, ADDR_MOD10, ADDR_MOD32};
	logic [7:0] rm [3] = '{8'h77, 8'h7F, 8'h7F};

	tx_symbol_shaper #(.QUARTER_CYCLES(4)) dut (.mclk(mclk),
		.reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .tx_out(tx_out), .tx_active(tx_active));
	rf_card_model card (.mclk(mclk), .reset_n(reset_n), .tx_out(tx_out),
		.tx_active(tx_active), .qbits(qbits), .nq(nq));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge mclk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge mclk);
		bus_req <= '0;
		#1;
		chk({56'h0, bus_rdata}, {56'h0, e}, m);
	endtask

	task automatic cfg(input bit pb, input bit mil, input int kind,
		input bit inv, input int env);
		pb_s = pb;
		mil_s = mil;
		kind_s = kind;
		inv_s = inv;
		env_s = env;
		wr(pb ? ADDR_MOD32 : ADDR_MOD10, {1'b0, mil, kind[1:0], inv, env[2:0]});
	endtask

	// Expected field level in quarter q of a bit
	function automatic logic expq(input bit b, input bit p, input int q);
		logic l;
		case (env_s)
			0, 3: l = b;
			1: l = b ^ (q >= 2);
			4: l = b & (q >= 2);
			5: l = pb_s ? (b & (q < 2)) : (b & (q >= 2));
			default: l = 1'b0;
		endcase
		if (mil_s) begin
			l = b ? (q == 2) : (q == 0 && !p);
		end else if (kind_s != 0) begin
			l = l & (kind_s == 1 ? q == 0 : kind_s == 2 ? q >= 2 : q == 2);
		end
		return l ^ inv_s;
	endfunction

	function automatic int trans(input logic [63:0] v);
		int c;
		c = 0;
		for (int i = 0; i < 63; i++) begin
			if (v[i] != v[i + 1]) begin
				c++;
			end
		end
		return c;
	endfunction

	// Sends one symbol; when n is nonzero, a second go is made while busy
	task automatic send(input logic [1:0] sym, input logic [15:0] bits,
		input int n, input bit cmpv);
		logic [63:0] ev;
		bit p;
		int i;
		ev = '0;
		p = 1'b0;
		for (i = 0; i < n; i++) begin
			for (int q = 0; q < 4; q++) begin
				ev = {ev[62:0], expq(bits[n - 1 - i], p, q)};
			end
			p = bits[n - 1 - i];
		end
		wr(ADDR_TX_CTRL, {1'b1, 5'b00000, sym});
		for (i = 0; i < 6 && tx_active !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk(tx_active, n != 0, "start");
		if (n != 0) begin
			rd(ADDR_TX_CTRL, {2'b00, sym, 3'b000, 1'b1}, "busy");
			wr(ADDR_TX_CTRL, {1'b1, 5'b00000, ~sym});
			for (i = 0; i < 3000 && tx_active !== 1'b0; i++) begin
				@(posedge mclk);
				#1;
			end
			repeat (3) @(posedge mclk);
			#1;
			chk(nq, 4 * n, "length");
			if (cmpv) begin
				chk(qbits, ev, "levels");
			end
			rd(ADDR_TX_CTRL, {2'b00, sym, 3'b000, 1'b0}, "idle");
		end
	endtask

	initial begin
		#(8 * 60000);
		errors++;
		stop_test();
	end

	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		bus_req = '0;
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(ra[i], RESET_BYTE, "reset");
			wr(ra[i], 8'hFF);
			rd(ra[i], rm[i], "mask");
		end
		wr(8'h70, 8'hFF);
		rd(8'h70, 8'h00, "unmapped");
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(ADDR_BURST_CTRL, 8'h00);
		@(posedge mclk);
		clk_en <= 1'b1;
		rd(ADDR_BURST_CTRL, 8'h77, "frozen");
		$display("test registers done");
		wr(ADDR_BURST_CTRL, 8'h00);
		wr(ADDR_SYM0_LO, 8'h01);
		wr(ADDR_LEN10, 8'h00);
		wr(ADDR_SYM2, 8'h01);
		wr(ADDR_LEN32, 8'h00);
		for (int pb = 0; pb < 2; pb++) begin
			for (int e = 0; e < 8; e++) begin
				for (int v = 0; v < 2; v++) begin
					cfg(pb, 1'b0, 0, v, e);
					send(pb ? 2'd2 : 2'd0, 16'h0001, 1, 1'b1);
				end
			end
			for (int k = 1; k < 4; k++) begin
				cfg(pb, 1'b0, k, 1'b0, 0);
				send(pb ? 2'd2 : 2'd0, 16'h0001, 1, 1'b1);
			end
		end
		$display("test envelopes done");
		wr(ADDR_SYM0_LO, 8'h06);
		wr(ADDR_LEN10, 8'h02);
		wr(ADDR_SYM2, 8'h06);
		wr(ADDR_LEN32, 8'h02);
		for (int pb = 0; pb < 2; pb++) begin
			cfg(pb, 1'b1, 1, 1'b0, 0);
			send(pb ? 2'd2 : 2'd0, 16'h0006, 3, 1'b1);
		end
		$display("test miller done");
		cfg(1'b0, 1'b0, 0, 1'b0, 0);
		wr(ADDR_BURST_LEN, 8'h02);
		wr(ADDR_BURST_CTRL, 8'h03);
		send(2'd0, 16'h0000, 3, 1'b1);
		wr(ADDR_BURST_CTRL, 8'h05);
		wr(ADDR_SYM0_LO, 8'h02);
		wr(ADDR_LEN10, 8'h01);
		send(2'd0, 16'h001E, 5, 1'b1);
		wr(ADDR_BURST_CTRL, 8'h70);
		send(2'd1, 16'h0007, 3, 1'b1);
		wr(ADDR_BURST_CTRL, 8'h30);
		send(2'd1, 16'h0000, 3, 1'b1);
		wr(ADDR_BURST_CTRL, 8'h20);
		send(2'd1, 16'h0000, 0, 1'b1);
		wr(ADDR_BURST_CTRL, 8'h00);
		wr(ADDR_SYM1_LO, 8'h05);
		wr(ADDR_LEN10, 8'h20);
		send(2'd1, 16'h0005, 3, 1'b1);
		wr(ADDR_LEN10, 8'h0F);
		wr(ADDR_SYM0_HI, 8'h80);
		wr(ADDR_SYM0_LO, 8'h01);
		send(2'd0, 16'h8001, 16, 1'b1);
		$display("test bursts done");
		wr(ADDR_SYM0_HI, 8'hFF);
		wr(ADDR_SYM0_LO, 8'hFF);
		cfg(1'b0, 1'b0, 0, 1'b0, 3);
		send(2'd0, 16'hFFFF, 16, 1'b0);
		chk(trans(qbits), 1, "slow carrier");
		wr(ADDR_FREQ10, 8'h08);
		send(2'd0, 16'hFFFF, 16, 1'b0);
		chk(trans(qbits), 3, "fast carrier");
		$display("test subcarrier done");
		stop_test();
	end
endmodule
`default_nettype wire
